// ===== bench/adc_sequential_sample_control_tb.sv
// Self-checking bench of the sequential sample controller with its core model.
`timescale 1ns/10ps
`default_nettype none
module adc_sequential_sample_control_tb import asc_pkg::*;;
    logic              clk, resetn, bus_wr, bus_rd, pwm, ext, sh, tk, rv, rr, df;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdat;
    logic [RES_W-1:0]  cd;
    logic [CHAN_W-1:0] ch;
    logic [ACQ_W-1:0]  acq;
    asc_word_t         rw;
    logic [DATA_W-1:0] rd_q[$];
    asc_word_t         wq[$];
    int                tq[$];
    int                fails = 0, cmp_count = 0, cyc = 0, tcyc = 0, lr = -1, dn = 0, rn = 0;
    bit                tchk, spchk, vchk, abrt, rd_d, sh_d, rv_d;
    logic [ADDR_W-1:0] ofs[7] = '{OFS_CTRL_ONE, OFS_CTRL_THREE, OFS_CHAN_SEL, OFS_SW_TRIG,
                                  OFS_STATUS, OFS_RESULT, 8'h20};

    asc_sequencer i_dut (.clk(clk), .resetn(resetn), .bus_addr(addr), .bus_wdata(wd),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(rdat), .pwm_event_source(pwm),
        .external_start_pin(ext), .core_data(cd), .sample_hold(sh), .sample_take(tk),
        .conv_channel(ch), .result_valid(rv), .result_ready(rr), .result_word(rw), .done_flag(df));
    asc_core_model i_core (.clk(clk), .resetn(resetn), .sample_hold(sh), .sample_take(tk),
        .conv_channel(ch), .core_data(cd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic stop_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [DATA_W-1:0] g, e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_word(input asc_word_t g, e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t result word %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_cyc(input int g, e);
        cmp_count++;
        if (g != e) begin
            fails++;
            $display("ERROR %0t count %0d expected %0d", $time, g, e);
        end
    endtask

    function automatic asc_word_t ew(input logic [CHAN_W-1:0] c);
        return {c, c, ~c, c};
    endfunction

    function automatic logic [DATA_W-1:0] c1(input logic [ACQ_W-1:0] a, input logic ct, e, p, s);
        return 32'({a, 4'h0, ct, e, p, s});
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        bus_rd <= 1'b1;
        addr <= a;
        rd_q.push_back(e);
        @(posedge clk);
        bus_rd <= 1'b0;
    endtask

    // Completion is bounded; a missing one ends the run at once.
    task automatic wait_done(input int n);
        int k = 0;
        while (dn < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        if (dn < n) begin
            fails++;
            $display("ERROR %0t no completion", $time);
            stop_test();
        end
    endtask

    // Values seen here are those of the cycle that ends at this edge.
    always @(posedge clk) begin
        cyc++;
        if (rd_d) cmp_val(rdat, rd_q.pop_front());
        rd_d = bus_rd;
        if ((bus_wr && addr == OFS_SW_TRIG && wd[B_SW_TRIG]) || pwm) tcyc = cyc;
        if (sh && !sh_d) begin
            rn++;
            if (tchk) cmp_cyc(cyc - tcyc, 26);
            if (spchk && lr >= 0) cmp_cyc(cyc - lr, (2 + acq) * 10);
            tchk = 0;
            lr = cyc;
        end
        if (tk && !abrt) cmp_cyc(cyc - lr, (acq + 1) * 10);
        if (tk) tq.push_back(cyc);
        if (rv && !rv_d && vchk) cmp_cyc(cyc - tq[$], 40);
        if (df) begin
            dn++;
            cmp_cyc(cyc - tq.pop_front(), 42);
        end
        if (rv && rr) begin
            if (wq.size() == 0) begin
                fails++;
                $display("ERROR %0t unexpected result word", $time);
            end else begin
                cmp_word(rw, wq.pop_front());
            end
        end
        sh_d = sh;
        rv_d = rv;
    end

    initial begin
        int r0;
        int d0;
        logic [CHAN_W-1:0] c;
        resetn = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        addr = '0;
        wd = '0;
        pwm = 1'b0;
        ext = 1'b0;
        rr = 1'b1;
        acq = '0;
        void'($urandom(31));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        // Bandgap alone is not enough: a trigger must still be ignored.
        wr(OFS_CTRL_THREE, 32'hc0);
        r0 = rn;
        wr(OFS_SW_TRIG, 32'h1);
        repeat (60) @(posedge clk);
        cmp_cyc(rn, r0);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL_THREE, 32'he0);
        rd(OFS_CTRL_THREE, 32'he0);
        rd(OFS_STATUS, 32'h4);
        vchk = 1;
        for (int s = 0; s < 3; s++) begin
            c = (s == 0) ? 4'h0 : (s == 1) ? 4'hf : 4'($urandom);
            acq = 4'($urandom);
            wr(OFS_CHAN_SEL, 32'(c));
            wr(OFS_CTRL_ONE, c1(acq, 1'b0, s == 2, s == 1, 1'b0));
            wq.push_back(ew(c));
            tchk = (s != 2);
            d0 = dn;
            @(posedge clk);
            if (s == 0) wr(OFS_SW_TRIG, 32'h1);
            if (s == 1) pwm <= 1'b1;
            if (s == 2) ext <= 1'b1;
            @(posedge clk);
            pwm <= 1'b0;
            repeat (5) @(posedge clk);
            ext <= 1'b0;
            wait_done(d0 + 1);
            rd(OFS_RESULT, {12'h0, c, 4'h0, c, ~c, c});
        end
        vchk = 0;
        wr(OFS_CTRL_ONE, c1(4'h0, 1'b0, 1'b0, 1'b1, 1'b1));
        r0 = rn;
        wr(OFS_SW_TRIG, 32'h1);
        repeat (60) @(posedge clk);
        cmp_cyc(rn, r0);
        // Receiver stalls: continuous run must stop once both slots are spoken for.
        acq = 4'h0;
        rr <= 1'b0;
        wr(OFS_CHAN_SEL, 32'h5);
        wr(OFS_CTRL_ONE, c1(4'h0, 1'b1, 1'b0, 1'b0, 1'b0));
        spchk = 1;
        tchk = 1;
        lr = -1;
        wq.push_back(ew(4'h5));
        wq.push_back(ew(4'h5));
        d0 = dn;
        wr(OFS_SW_TRIG, 32'h1);
        wait_done(d0 + 2);
        repeat (5) @(posedge clk);
        rd(OFS_STATUS, 32'h26);
        r0 = rn;
        wr(OFS_SW_TRIG, 32'h1);
        repeat (40) @(posedge clk);
        cmp_cyc(rn, r0);
        spchk = 0;
        for (int k = 0; k < 60 && wq.size() > 0; k++) begin
            @(posedge clk);
            rr <= 1'($urandom);
        end
        cmp_cyc(wq.size(), 0);
        rd(OFS_STATUS, 32'h6);
        rr <= 1'b1;
        wr(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, 32'h4);
        // Power removed mid-pulse: the pulse ends and nothing is delivered.
        acq = 4'hf;
        wr(OFS_CTRL_ONE, c1(4'hf, 1'b0, 1'b0, 1'b0, 1'b0));
        abrt = 1;
        tchk = 1;
        d0 = dn;
        wr(OFS_SW_TRIG, 32'h1);
        repeat (60) @(posedge clk);
        wr(OFS_CTRL_THREE, 32'hc0);
        @(posedge clk);
        @(negedge clk);
        cmp_val({31'h0, sh}, 32'h0);
        repeat (120) @(posedge clk);
        cmp_cyc(dn, d0);
        tq.delete();
        abrt = 0;
        stop_test();
    end
endmodule
`default_nettype wire

// ===== bench/asc_core_model.sv
// Behavioural model of the analog core that hands one code per sample pulse.
`timescale 1ns/10ps
`default_nettype none
module asc_core_model import asc_pkg::*; (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              sample_hold,
    input  wire logic              sample_take,
    input  wire logic [CHAN_W-1:0] conv_channel,
    output logic      [RES_W-1:0]  core_data
);
    logic [CHAN_W-1:0] chan_reg;
    logic [RES_W-1:0]  noise_reg;
    // Outside the capture the output moves every cycle, so a mistimed capture shows.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_reg  <= CHAN_RST;
            noise_reg <= 12'h5a3;
        end else begin
            noise_reg <= noise_reg + 12'h6b1;
            if (sample_hold) begin
                chan_reg <= conv_channel;
            end
        end
    end
    assign core_data = sample_hold ? {conv_channel, ~conv_channel, conv_channel}
                     : sample_take ? {chan_reg, ~chan_reg, chan_reg} : noise_reg;
endmodule
`default_nettype wire

// ===== pkg/asc_pkg.sv
// Constants, register map and carrier types of the sequential sample controller.
package asc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CHAN_W = 4;
    localparam int RES_W  = 12;
    localparam int ACQ_W  = 4;

    localparam logic [ADDR_W-1:0] OFS_CTRL_ONE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_THREE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CHAN_SEL   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SW_TRIG    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RESULT     = 8'h14;

    localparam int B_SIM_SEL   = 0;
    localparam int B_PWM_EN    = 1;
    localparam int B_EXT_EN    = 2;
    localparam int B_CONT      = 3;
    localparam int ACQ_LSB     = 8;
    localparam int B_BG0       = 6;
    localparam int BG_W        = 2;
    localparam int B_PWR       = 5;
    localparam int CHAN_LSB    = 0;
    localparam int B_SW_TRIG   = 0;
    localparam int B_ST_BUSY   = 0;
    localparam int B_ST_DONE   = 1;
    localparam int B_ST_REF    = 2;
    localparam int ST_OCC_LSB  = 4;
    localparam int RES_LSB     = 0;
    localparam int RES_CH_LSB  = 16;

    localparam logic [ACQ_W-1:0]  ACQ_RST  = 4'h0;
    localparam logic [BG_W-1:0]   BG_RST   = 2'h0;
    localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;

    localparam int SYS_PERIOD_NS  = 8;
    localparam int CONV_PERIOD_NS = 80;
    localparam int CYC_PER_HALF   = CONV_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam int DIV_W          = 3;
    localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(CYC_PER_HALF - 1);

    localparam int HCNT_W = 6;
    localparam logic [HCNT_W-1:0] DLY_LAST = 6'h04;
    localparam logic [HCNT_W-1:0] GAP_LAST = 6'h01;
    localparam int PIPE_N    = 8;
    localparam int FLAG_DLY  = 2;
    localparam logic [2:0] BUF_SLOTS = 3'h2;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [RES_W-1:0]  data;
    } asc_word_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DELAY  = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_GAP    = 2'b11
    } asc_state_t;

endpackage

// ===== rtl/asc_sequencer.sv
// Sequential single-channel sample controller with register port and result buffer.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module asc_sequencer
    import asc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [DATA_W-1:0] bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [DATA_W-1:0] bus_rdata,
    input  wire logic              pwm_event_source,
    input  wire logic              external_start_pin,
    input  wire logic [RES_W-1:0]  core_data,
    output logic                   sample_hold,
    output logic                   sample_take,
    output logic      [CHAN_W-1:0] conv_channel,
    output logic                   result_valid,
    input  wire logic              result_ready,
    output asc_word_t              result_word,
    output logic                   done_flag
);

    logic [ACQ_W-1:0]    acq_reg, acq_run_reg;
    logic                sim_sel_reg, pwm_en_reg, ext_en_reg, cont_reg;
    logic [BG_W-1:0]     bg_reg;
    logic                pwr_reg, done_sticky_reg, res_upd_reg;
    logic [CHAN_W-1:0]   chan_reg, conv_channel_reg;
    logic [DATA_W-1:0]   rdata_reg, rd_next;
    logic                ext_s1_reg, ext_s2_reg, ext_s3_reg;
    logic [DIV_W-1:0]    div_reg;
    asc_state_t          st_reg;
    logic [HCNT_W-1:0]   half_cnt_reg;
    logic                sample_hold_reg, sample_take_reg;
    logic [PIPE_N-1:0]   line_v_reg;
    asc_word_t           line_w_reg [PIPE_N];
    asc_word_t           result_reg, head_reg, spare_reg;
    logic [1:0]          inflight_reg;
    logic                head_valid_reg, spare_valid_reg;
    logic [FLAG_DLY-1:0] flag_pipe_reg;

    logic                wr_one, wr_three, wr_chan, wr_status, sw_trig;
    logic                ext_rise, trig_any, room, can_run, accept;
    logic                half_tick, dly_done, sh_done, gap_done, enter_sample;
    logic                res_push, pop;
    logic [1:0]          occ;

    assign wr_one    = bus_wr && (bus_addr == OFS_CTRL_ONE);
    assign wr_three  = bus_wr && (bus_addr == OFS_CTRL_THREE);
    assign wr_chan   = bus_wr && (bus_addr == OFS_CHAN_SEL);
    assign wr_status = bus_wr && (bus_addr == OFS_STATUS);
    assign sw_trig   = bus_wr && (bus_addr == OFS_SW_TRIG) && bus_wdata[B_SW_TRIG];

    // Control registers; power bits are taken in any order or all at once.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            acq_reg     <= ACQ_RST;
            sim_sel_reg <= 1'b0;
            pwm_en_reg  <= 1'b0;
            ext_en_reg  <= 1'b0;
            cont_reg    <= 1'b0;
            bg_reg      <= BG_RST;
            pwr_reg     <= 1'b0;
            chan_reg    <= CHAN_RST;
        end else begin
            if (wr_one) begin
                acq_reg     <= bus_wdata[ACQ_LSB +: ACQ_W];
                sim_sel_reg <= bus_wdata[B_SIM_SEL];
                pwm_en_reg  <= bus_wdata[B_PWM_EN];
                ext_en_reg  <= bus_wdata[B_EXT_EN];
                cont_reg    <= bus_wdata[B_CONT];
            end
            if (wr_three) begin
                bg_reg  <= bus_wdata[B_BG0 +: BG_W];
                pwr_reg <= bus_wdata[B_PWR];
            end
            if (wr_chan) begin
                chan_reg <= bus_wdata[CHAN_LSB +: CHAN_W];
            end
        end
    end

    // The start pin is asynchronous, so it is synchronised before edge detection.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {ext_s3_reg, ext_s2_reg, ext_s1_reg} <= 3'h0;
        end else begin
            {ext_s3_reg, ext_s2_reg, ext_s1_reg} <= {ext_s2_reg, ext_s1_reg, external_start_pin};
        end
    end

    assign ext_rise = ext_s2_reg && !ext_s3_reg;
    assign trig_any = sw_trig || (pwm_event_source && pwm_en_reg) || (ext_rise && ext_en_reg);

    // A sample is only started when a buffer slot is reserved for it, so no word is lost on a stall.
    assign occ     = {1'b0, head_valid_reg} + {1'b0, spare_valid_reg};
    assign room    = ({1'b0, inflight_reg} + {1'b0, occ}) < BUF_SLOTS;
    assign can_run = pwr_reg && !sim_sel_reg && room;
    assign accept  = (st_reg == ST_IDLE) && can_run && trig_any;

    // Half-period ticks of the converter clock; restarting on a trigger fixes the 2.5 clock delay.
    assign half_tick = (div_reg == HALF_LAST);

    always_ff @(posedge clk) begin
        if (!resetn || accept || half_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign dly_done     = (st_reg == ST_DELAY) && half_tick && (half_cnt_reg == DLY_LAST);
    assign sh_done      = (st_reg == ST_SAMPLE) && half_tick && (half_cnt_reg == {1'b0, acq_run_reg, 1'b1});
    assign gap_done     = (st_reg == ST_GAP) && half_tick && (half_cnt_reg == GAP_LAST);
    assign enter_sample = pwr_reg && (dly_done || (gap_done && cont_reg && can_run));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg           <= ST_IDLE;
            half_cnt_reg     <= '0;
            acq_run_reg      <= ACQ_RST;
            sample_hold_reg  <= 1'b0;
            sample_take_reg  <= 1'b0;
            conv_channel_reg <= CHAN_RST;
        end else begin
            sample_take_reg <= 1'b0;
            if (!pwr_reg) begin
                st_reg          <= ST_IDLE;
                sample_hold_reg <= 1'b0;
            end else if (enter_sample) begin
                st_reg           <= ST_SAMPLE;
                half_cnt_reg     <= '0;
                sample_hold_reg  <= 1'b1;
                conv_channel_reg <= chan_reg;
                acq_run_reg      <= acq_reg;
            end else begin
                unique case (st_reg)
                    ST_IDLE: begin
                        if (accept) begin
                            st_reg       <= ST_DELAY;
                            half_cnt_reg <= '0;
                        end
                    end
                    ST_DELAY, ST_GAP: begin
                        if (gap_done) begin
                            st_reg <= ST_IDLE;
                        end else if (half_tick) begin
                            half_cnt_reg <= half_cnt_reg + 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        if (sh_done) begin
                            st_reg          <= ST_GAP;
                            half_cnt_reg    <= '0;
                            sample_hold_reg <= 1'b0;
                            sample_take_reg <= 1'b1;
                        end else if (half_tick) begin
                            half_cnt_reg <= half_cnt_reg + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // The core pipeline is modelled as a fixed-length line stepped on half ticks.
    always_ff @(posedge clk) begin
        if (!resetn || !pwr_reg) begin
            line_v_reg <= '0;
        end else if (half_tick) begin
            line_v_reg <= {line_v_reg[PIPE_N-2:0], sh_done};
        end
    end

    always_ff @(posedge clk) begin
        if (half_tick) begin
            line_w_reg[0] <= {conv_channel_reg, core_data};
        end
    end

    for (genvar i = 1; i < PIPE_N; i++) begin : g_pipe
        always_ff @(posedge clk) begin
            if (half_tick) begin
                line_w_reg[i] <= line_w_reg[i-1];
            end
        end
    end

    assign res_push = pwr_reg && half_tick && line_v_reg[PIPE_N-1];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_reg  <= '0;
            res_upd_reg <= 1'b0;
        end else begin
            res_upd_reg <= res_push;
            if (res_push) begin
                result_reg <= line_w_reg[PIPE_N-1];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !pwr_reg) begin
            inflight_reg <= '0;
        end else begin
            inflight_reg <= inflight_reg + 2'(enter_sample) - 2'(res_push);
        end
    end

    // Two-entry buffer: the head drives the output port, the spare catches a word during a stall.
    assign pop = head_valid_reg && result_ready;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            head_valid_reg  <= 1'b0;
            spare_valid_reg <= 1'b0;
            head_reg        <= '0;
            spare_reg       <= '0;
        end else if (pop || !head_valid_reg) begin
            if (spare_valid_reg) begin
                head_reg        <= spare_reg;
                head_valid_reg  <= 1'b1;
                spare_reg       <= line_w_reg[PIPE_N-1];
                spare_valid_reg <= res_push;
            end else begin
                head_reg       <= line_w_reg[PIPE_N-1];
                head_valid_reg <= res_push;
            end
        end else if (res_push) begin
            spare_reg       <= line_w_reg[PIPE_N-1];
            spare_valid_reg <= 1'b1;
        end
    end

    // The done flag trails the result update by a fixed number of cycles.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_pipe_reg <= '0;
        end else begin
            flag_pipe_reg <= {flag_pipe_reg[FLAG_DLY-2:0], res_upd_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            done_sticky_reg <= 1'b0;
        end else if (flag_pipe_reg[FLAG_DLY-1]) begin
            done_sticky_reg <= 1'b1;
        end else if (wr_status && bus_wdata[B_ST_DONE]) begin
            done_sticky_reg <= 1'b0;
        end
    end

    always_comb begin
        rd_next = '0;
        unique case (bus_addr)
            OFS_CTRL_ONE: begin
                rd_next[ACQ_LSB +: ACQ_W] = acq_reg;
                rd_next[B_SIM_SEL]        = sim_sel_reg;
                rd_next[B_PWM_EN]         = pwm_en_reg;
                rd_next[B_EXT_EN]         = ext_en_reg;
                rd_next[B_CONT]           = cont_reg;
            end
            OFS_CTRL_THREE: begin
                rd_next[B_BG0 +: BG_W] = bg_reg;
                rd_next[B_PWR]         = pwr_reg;
            end
            OFS_CHAN_SEL: begin
                rd_next[CHAN_LSB +: CHAN_W] = chan_reg;
            end
            OFS_STATUS: begin
                rd_next[B_ST_BUSY]        = (st_reg != ST_IDLE) || (inflight_reg != '0);
                rd_next[B_ST_DONE]        = done_sticky_reg;
                rd_next[B_ST_REF]         = (&bg_reg) && pwr_reg;
                rd_next[ST_OCC_LSB +: 2]  = occ;
            end
            OFS_RESULT: begin
                rd_next[RES_LSB +: RES_W]     = result_reg.data;
                rd_next[RES_CH_LSB +: CHAN_W] = result_reg.chan;
            end
            default: begin
                rd_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn || !bus_rd) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rd_next;
        end
    end

    assign bus_rdata    = rdata_reg;
    assign sample_hold  = sample_hold_reg;
    assign sample_take  = sample_take_reg;
    assign conv_channel = conv_channel_reg;
    assign result_valid = head_valid_reg;
    assign result_word  = head_reg;
    assign done_flag    = flag_pipe_reg[FLAG_DLY-1];

    localparam int A_DLY = 26, A_LAT = 40, A_FLAG = 2, A_CONV = 2 * CYC_PER_HALF;

    logic [7:0] sh_cnt_reg;

    always_ff @(posedge clk) begin
        if (!resetn || !sample_hold_reg) begin
            sh_cnt_reg <= '0;
        end else begin
            sh_cnt_reg <= sh_cnt_reg + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_accept;
        accept;
    endsequence

    sequence s_sh_rise;
        $rose(sample_hold_reg);
    endsequence

    a_start_delay: assert property (disable iff (!resetn || !pwr_reg) s_accept |-> ##[A_DLY:A_DLY] s_sh_rise)
        else $error("Sample pulse did not start 2.5 converter clocks after the trigger.");
    a_sh_width: assert property ($fell(sample_hold_reg) && pwr_reg |-> sh_cnt_reg == (int'(acq_run_reg) + 1) * A_CONV)
        else $error("Sample pulse width does not match the acquisition field.");
    a_sample_edge: assert property (sample_take_reg |-> $fell(sample_hold_reg) && !sample_hold_reg)
        else $error("Sample taken away from the falling edge of the pulse.");
    a_first_result: assert property (disable iff (!resetn || !pwr_reg) sample_take_reg |-> ##[A_LAT:A_LAT] res_upd_reg)
        else $error("Result not updated four converter clocks after sampling.");
    a_flag_after: assert property (res_upd_reg |-> ##[A_FLAG:A_FLAG] done_flag)
        else $error("Done flag missing after result update.");
    a_flag_not_early: assert property (done_flag |-> $past(res_upd_reg, 2))
        else $error("Done flag raised without a preceding result update.");
    a_power_gate: assert property (!pwr_reg |=> !sample_hold_reg && !res_upd_reg && st_reg == ST_IDLE)
        else $error("Activity while the converter is powered down.");
    a_mode_gate: assert property (sim_sel_reg && st_reg == ST_IDLE |=> st_reg == ST_IDLE)
        else $error("Sequential start while simultaneous mode is selected.");
    a_channel_hold: assert property (sample_hold_reg && $past(sample_hold_reg) |-> $stable(conv_channel_reg))
        else $error("Channel changed during a sample pulse.");

endmodule

`default_nettype wire
